/* logic/arcc_top.v */
/*
  Result holding, converter clock generation, mode selection and
  rounding of a successive approximation converter, with its registers
  on a plain read/write port. Assumes the alternate and asynchronous
  clock sources arrive as one-cycle ticks synchronous to clk_sys_i, and
  that the analog array answers the trial code on cmp_i.
*/
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "arcc_defines.vh"
module arcc_top (
  // Clock and reset.
  input wire clk_sys_i,
  input wire reset_n_i,
  // Register port.
  input wire [1:0] addr_i,
  input wire [7:0] wr_data_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rd_data_o,
  // Clock sources and system state.
  input wire alt_clk_tick_i,
  input wire async_clk_tick_i,
  input wire stop_mode_i,
  input wire hw_trigger_i,
  // Analog array.
  input wire cmp_i,
  output reg conv_on_o,
  output reg sample_o,
  output reg low_power_o,
  output reg async_clk_run_o,
  output reg [4:0] channel_o,
  output reg [`ARCC_RAW_W-1:0] trial_o,
  // Status.
  output reg complete_o
);

  // Rounds the raw approximation to eight or ten bits, saturating.
  function [9:0] round_res;
    input [`ARCC_RAW_W-1:0] raw;
    input ten;
    reg [11:0] sum;
    begin
      if (ten) begin
        sum = {1'b0, raw} + 12'h001;
        round_res = sum[11] ? 10'h3FF : sum[10:1];
      end else begin
        sum = {1'b0, raw} + 12'h004;
        round_res = sum[11] ? 10'h0FF : {2'h0, sum[10:3]};
      end
    end
  endfunction

  // One-hot sequencing states.
  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_WAIT = 3'b100;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [7:0] clk_cfg_ff;
  reg int_en_ff;
  reg cont_ff;
  reg [4:0] chan_ff;
  reg complete_ff;
  reg locked_ff;
  reg [1:0] res_high_ff;
  reg [7:0] res_low_ff;
  reg [7:0] rd_mux;

  wire wr_sc;
  wire wr_cc;
  wire rd_high;
  wire rd_low;
  wire [1:0] mode;
  wire ten_bit;
  wire hw_mode;
  wire async_en;
  wire chan_off;
  wire stop_kill;
  wire src_tick;
  wire converter_clock_tick;
  wire sar_busy;
  wire sar_sample;
  wire sar_done;
  wire [`ARCC_RAW_W-1:0] sar_trial;
  wire [`ARCC_RAW_W-1:0] sar_raw;
  wire [9:0] rounded;
  wire sw_start;
  wire hw_start;
  wire cont_start;
  wire start;
  wire abort;
  wire take_result;

  // Register port decode.
  assign wr_sc = wr_i && (addr_i == `ARCC_OFF_STATUS_CONTROL);
  assign wr_cc = wr_i && (addr_i == `ARCC_OFF_CLOCK_CONFIG);
  assign rd_high = rd_i && (addr_i == `ARCC_OFF_RESULT_HIGH);
  assign rd_low = rd_i && (addr_i == `ARCC_OFF_RESULT_LOW);

  // Mode decoding; the reserved code runs as 10-bit software mode.
  assign mode = clk_cfg_ff[`ARCC_CC_MODE_HI:`ARCC_CC_MODE_LO];
  assign ten_bit = (mode != `ARCC_MODE_8BIT_SW);
  assign hw_mode = (mode == `ARCC_MODE_10BIT_HW);
  assign async_en = clk_cfg_ff[`ARCC_CC_ASYNC_EN];
  assign chan_off = (chan_ff == `ARCC_CHAN_OFF);

  // Without the asynchronous clock, stop mode ends all conversion work.
  assign stop_kill = stop_mode_i && !async_en;

  // Input clock choice for the divider.
  assign src_tick = async_en ? async_clk_tick_i :
                    (clk_cfg_ff[`ARCC_CC_INPUT_CLK] ? 1'b1 :
                     alt_clk_tick_i);

  // Start sources.
  assign sw_start = wr_sc && !hw_mode &&
    (wr_data_i[`ARCC_SC_CHAN_HI:`ARCC_SC_CHAN_LO] != `ARCC_CHAN_OFF) &&
    !stop_kill;
  assign hw_start = hw_mode && hw_trigger_i && !chan_off &&
    !stop_kill && (state_ff == ST_WAIT) && !wr_sc && !wr_cc;
  assign cont_start = cont_ff && !chan_off && !stop_kill && sar_done &&
    !wr_sc && !wr_cc && !hw_mode;
  assign start = sw_start || hw_start || cont_start;

  // A status write, a clock register write or stop without the asynchronous clock abort.
  assign abort = wr_sc || wr_cc || stop_kill;

  // Rounded result and whether it may reach the result registers.
  assign rounded = round_res(sar_raw, ten_bit);
  assign take_result = sar_done && !(ten_bit && locked_ff);

  arcc_clk_div u_clk_div (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .run_i(sar_busy),
    .src_tick_i(src_tick),
    .div_sel_i(clk_cfg_ff[`ARCC_CC_DIV_HI:`ARCC_CC_DIV_LO]),
    .converter_clock_tick_o(converter_clock_tick)
  );

  arcc_sar u_sar (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .start_i(start),
    .abort_i(abort),
    .tick_i(converter_clock_tick),
    .long_sample_i(clk_cfg_ff[`ARCC_CC_LONG_SAMPLE]),
    .cmp_i(cmp_i),
    .busy_o(sar_busy),
    .sample_o(sar_sample),
    .done_o(sar_done),
    .trial_o(sar_trial),
    .raw_o(sar_raw)
  );

  // Sequencing: idle, converting, or waiting for a hardware trigger.
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_CONV;
        end else if (wr_sc && hw_mode) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_CONV: begin
        if (start) begin
          nxt_state = ST_CONV;
        end else if (abort) begin
          nxt_state = (wr_sc && hw_mode) ? ST_WAIT : ST_IDLE;
        end else if (sar_done) begin
          nxt_state = (hw_mode && cont_ff) ? ST_WAIT : ST_IDLE;
        end
      end
      ST_WAIT: begin
        if (start) begin
          nxt_state = ST_CONV;
        end else if (wr_cc || stop_kill || chan_off) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Control registers; reset gives 8-bit mode and the off channel.
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clk_cfg_ff <= `ARCC_RST_CLOCK_CONFIG;
      int_en_ff <= 1'b0;
      cont_ff <= 1'b0;
      chan_ff <= `ARCC_CHAN_OFF;
    end else begin
      if (wr_cc) begin
        clk_cfg_ff <= wr_data_i;
      end
      if (wr_sc) begin
        int_en_ff <= wr_data_i[`ARCC_SC_INT_ENABLE];
        cont_ff <= wr_data_i[`ARCC_SC_CONTINUOUS];
        chan_ff <= wr_data_i[`ARCC_SC_CHAN_HI:`ARCC_SC_CHAN_LO];
      end else if (wr_cc || stop_kill) begin
        cont_ff <= 1'b0;
      end
    end
  end

  // Result registers, interlock and complete flag.
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      res_high_ff <= 2'h0;
      res_low_ff <= 8'h00;
      locked_ff <= 1'b0;
      complete_ff <= 1'b0;
    end else begin
      if (take_result) begin
        res_high_ff <= rounded[9:8];
        res_low_ff <= rounded[7:0];
      end
      if (rd_low || !ten_bit) begin
        locked_ff <= 1'b0;
      end else if (rd_high) begin
        locked_ff <= 1'b1;
      end
      if (sar_done) begin
        complete_ff <= 1'b1;
      end else if (wr_sc || rd_low) begin
        complete_ff <= 1'b0;
      end
    end
  end

  // Read data multiplexer; upper result-high bits always read zero.
  always @* begin
    case (addr_i)
      `ARCC_OFF_STATUS_CONTROL: begin
        rd_mux = {complete_ff, int_en_ff, cont_ff, chan_ff};
      end
      `ARCC_OFF_RESULT_HIGH: begin
        rd_mux = {6'h00, res_high_ff};
      end
      `ARCC_OFF_RESULT_LOW: begin
        rd_mux = res_low_ff;
      end
      `ARCC_OFF_CLOCK_CONFIG: begin
        rd_mux = clk_cfg_ff;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // Registered outputs.
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 8'h00;
      conv_on_o <= 1'b0;
      sample_o <= 1'b0;
      low_power_o <= 1'b0;
      async_clk_run_o <= 1'b0;
      channel_o <= `ARCC_CHAN_OFF;
      trial_o <= {`ARCC_RAW_W{1'b0}};
      complete_o <= 1'b0;
    end else begin
      rd_data_o <= rd_i ? rd_mux : 8'h00;
      conv_on_o <= sar_busy && !chan_off;
      sample_o <= sar_sample;
      low_power_o <= clk_cfg_ff[`ARCC_CC_LOW_POWER];
      async_clk_run_o <= async_en && sar_busy;
      channel_o <= chan_ff;
      trial_o <= sar_trial;
      complete_o <= complete_ff;
    end
  end

endmodule // arcc_top

/* logic/arcc_defines.vh */
/*
  Constants of the converter result and clock control block: register
  offsets, field positions, reset values and sequencing counts.
  Assumes inclusion by the top and sequencer design files and the assertion checker, by bare name.
*/
`ifndef ARCC_DEFINES_VH
`define ARCC_DEFINES_VH

// Register offsets on the 2-bit register port.
`define ARCC_OFF_STATUS_CONTROL 2'h0
`define ARCC_OFF_RESULT_HIGH 2'h1
`define ARCC_OFF_RESULT_LOW 2'h2
`define ARCC_OFF_CLOCK_CONFIG 2'h3

// Reset values.
`define ARCC_RST_STATUS_CONTROL 8'h1F
`define ARCC_RST_CLOCK_CONFIG 8'h00

// Field positions in status_control.
`define ARCC_SC_COMPLETE 7
`define ARCC_SC_INT_ENABLE 6
`define ARCC_SC_CONTINUOUS 5
`define ARCC_SC_CHAN_HI 4
`define ARCC_SC_CHAN_LO 0
`define ARCC_CHAN_OFF 5'h1F

// Field positions in converter_clock_config.
`define ARCC_CC_LOW_POWER 7
`define ARCC_CC_DIV_HI 6
`define ARCC_CC_DIV_LO 5
`define ARCC_CC_INPUT_CLK 4
`define ARCC_CC_MODE_HI 3
`define ARCC_CC_MODE_LO 2
`define ARCC_CC_LONG_SAMPLE 1
`define ARCC_CC_ASYNC_EN 0

// Mode field encodings.
`define ARCC_MODE_8BIT_SW 2'h0
`define ARCC_MODE_10BIT_SW 2'h1
`define ARCC_MODE_RESERVED 2'h2
`define ARCC_MODE_10BIT_HW 2'h3

// Sampling phase in converter clock edges, the half cycle before the
// first edge included: 3.5 and 23.5 cycles.
`define ARCC_SAMPLE_SHORT 5'h04
`define ARCC_SAMPLE_LONG 5'h18

// Approximation width: ten result bits plus one rounding bit.
`define ARCC_RAW_W 11
`define ARCC_RAW_MSB 11'h400

`endif

/* logic/arcc_clk_div.v */
/*
  Power-of-two divider that turns input clock ticks into converter
  clock ticks. Assumes one-cycle input ticks on the system clock.
*/
`timescale 1ns/1ps
module arcc_clk_div (
  // Clock and reset.
  input wire clk_sys_i,
  input wire reset_n_i,
  // Control.
  input wire run_i,
  input wire src_tick_i,
  input wire [1:0] div_sel_i,
  // Converter clock tick.
  output reg converter_clock_tick_o
);

  reg [2:0] cnt_ff;
  reg [1:0] div_ff;
  wire [2:0] last;

  // Divide by 1, 2, 4 or 8 from the two-bit field.
  assign last = (3'h1 << div_ff) - 3'h1;

  // A new ratio is taken only at a period boundary, so no short pulse.
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_ff <= 3'h0;
      div_ff <= 2'h0;
      converter_clock_tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_ff <= 3'h0;
      div_ff <= div_sel_i;
      converter_clock_tick_o <= 1'b0;
    end else if (src_tick_i) begin
      if (cnt_ff == last) begin
        cnt_ff <= 3'h0;
        div_ff <= div_sel_i;
        converter_clock_tick_o <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 3'h1;
        converter_clock_tick_o <= 1'b0;
      end
    end else begin
      converter_clock_tick_o <= 1'b0;
    end
  end

endmodule // arcc_clk_div

/* logic/arcc_sar.v */
/*
  Sampling and successive approximation sequencer. Assumes the analog
  comparator answers the trial code before the next converter tick.
*/
`timescale 1ns/1ps
`include "arcc_defines.vh"
module arcc_sar (
  // Clock and reset.
  input wire clk_sys_i,
  input wire reset_n_i,
  // Control.
  input wire start_i,
  input wire abort_i,
  input wire tick_i,
  input wire long_sample_i,
  input wire cmp_i,
  // Status and data.
  output reg busy_o,
  output reg sample_o,
  output reg done_o,
  output reg [`ARCC_RAW_W-1:0] trial_o,
  output reg [`ARCC_RAW_W-1:0] raw_o
);

  reg [4:0] samp_ff;
  reg [`ARCC_RAW_W-1:0] bit_ff;
  reg [`ARCC_RAW_W-1:0] code_ff;
  wire [`ARCC_RAW_W-1:0] kept;

  assign kept = cmp_i ? trial_o : code_ff;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_o <= 1'b0;
      sample_o <= 1'b0;
      done_o <= 1'b0;
      samp_ff <= 5'h00;
      bit_ff <= {`ARCC_RAW_W{1'b0}};
      code_ff <= {`ARCC_RAW_W{1'b0}};
      trial_o <= {`ARCC_RAW_W{1'b0}};
      raw_o <= {`ARCC_RAW_W{1'b0}};
    end else begin
      done_o <= 1'b0;
      if (abort_i || start_i) begin
        busy_o <= start_i;
        sample_o <= start_i;
        samp_ff <= long_sample_i ? `ARCC_SAMPLE_LONG :
                   `ARCC_SAMPLE_SHORT;
        bit_ff <= `ARCC_RAW_MSB;
        code_ff <= {`ARCC_RAW_W{1'b0}};
        trial_o <= `ARCC_RAW_MSB;
      end else if (busy_o && tick_i) begin
        if (sample_o) begin
          samp_ff <= samp_ff - 5'h01;
          if (samp_ff == 5'h01) begin
            sample_o <= 1'b0;
          end
        end else begin
          code_ff <= kept;
          bit_ff <= bit_ff >> 1;
          trial_o <= kept | (bit_ff >> 1);
          if (bit_ff[0]) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
            raw_o <= kept;
          end
        end
      end
    end
  end

endmodule // arcc_sar

/* test/arcc_top_asserts.sv */
/*
  Assertion checker for arcc_top, bound to its ports.
  Assumes one clock domain and the active low asynchronous reset.
*/
`timescale 1ns/1ps
`include "arcc_defines.vh"
module arcc_top_asserts (
  // Clock and reset.
  input wire clk_sys_i,
  input wire reset_n_i,
  // Register port.
  input wire [1:0] addr_i,
  input wire [7:0] wr_data_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rd_data_o,
  // Clock sources and system state.
  input wire alt_clk_tick_i,
  input wire async_clk_tick_i,
  input wire stop_mode_i,
  input wire hw_trigger_i,
  // Analog array and status.
  input wire cmp_i,
  input wire conv_on_o,
  input wire sample_o,
  input wire low_power_o,
  input wire async_clk_run_o,
  input wire [4:0] channel_o,
  input wire [`ARCC_RAW_W-1:0] trial_o,
  input wire complete_o
);
  reg [7:0] cfg_ff;
  wire sc_wr = wr_i && addr_i == 2'h0;
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_ff <= 8'h00;
    end else if (wr_i && addr_i == 2'h3) begin
      cfg_ff <= wr_data_i;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  property p_low_power;
    wr_i && addr_i == 2'h3 |-> ##2 low_power_o == $past(wr_data_i[7], 2);
  endproperty
  chk_write_starts: assert property (sc_wr && wr_data_i[4:0] != 5'h1F
    && !stop_mode_i && cfg_ff[3:2] != 2'h3 && !cfg_ff[0] |-> ##2 sample_o)
    else $error("status write did not start sampling");
  chk_off_idle: assert property (sc_wr && wr_data_i[4:0] == 5'h1F
    |-> ##2 (!conv_on_o && !sample_o)[*4]) else $error("converter not off");
  chk_flag_wr_clear: assert property (
    sc_wr && !conv_on_o |-> ##2 !complete_o)
    else $error("status write left flag set");
  chk_hw_no_start: assert property (
    sc_wr && cfg_ff[3:2] == 2'h3 |-> ##2 !sample_o)
    else $error("status write started in hardware mode");
  chk_flag_rd_clear: assert property (
    rd_i && addr_i == 2'h2 && !conv_on_o |-> ##2 !complete_o)
    else $error("low read left flag set");
  chk_low_power_bit: assert property (p_low_power)
    else $error("low power output wrong");
  chk_async_busy: assert property (async_clk_run_o |-> conv_on_o)
    else $error("async clock runs while idle");
  chk_async_sel: assert property (
    async_clk_run_o |-> cfg_ff[0] || $past(cfg_ff[0]))
    else $error("async clock runs while disabled");
  chk_stop_abort: assert property (
    stop_mode_i && !cfg_ff[0] |-> ##2 !conv_on_o)
    else $error("conversion continues in stop");
  chk_chan_off: assert property (
    channel_o == 5'h1F && $past(channel_o) == 5'h1F |-> !conv_on_o)
    else $error("converter on with channel off");
  chk_high_zero: assert property (
    rd_i && addr_i == 2'h1 |=> rd_data_o[7:2] == 6'h00)
    else $error("unused high bits not zero");
  cover property ($rose(complete_o));
  cover property (async_clk_run_o);
  cover property (sc_wr && wr_data_i[4:0] == 5'h1F);
endmodule // arcc_top_asserts
bind arcc_top arcc_top_asserts arcc_top_asserts_inst (.clk_sys_i,
  .reset_n_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
  .alt_clk_tick_i, .async_clk_tick_i, .stop_mode_i, .hw_trigger_i,
  .cmp_i, .conv_on_o, .sample_o, .low_power_o, .async_clk_run_o,
  .channel_o, .trial_o, .complete_o);

/* test/arcc_top_tb.sv */
/*
  Self-checking testbench of arcc_top through its register port.
  Assumes a comparator model that keeps a trial code not above vin.
*/
`timescale 1ns/1ps
module arcc_top_tb;
  reg clk_sys_i = 1'b0;
  reg reset_n_i = 1'b0;
  reg [1:0] addr_i = 2'h0;
  reg [7:0] wr_data_i = 8'h00;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg alt_clk_tick_i = 1'b0;
  reg async_clk_tick_i = 1'b0;
  reg stop_mode_i = 1'b0;
  reg hw_trigger_i = 1'b0;
  reg cmp_i = 1'b0;
  reg [10:0] vin = 11'h2A5;
  wire [7:0] rd_data_o;
  wire conv_on_o, sample_o, low_power_o, async_clk_run_o, complete_o;
  wire [4:0] channel_o;
  wire [10:0] trial_o;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int sh, ln;
  arcc_top arcc_top_inst (.clk_sys_i, .reset_n_i, .addr_i, .wr_data_i,
    .wr_i, .rd_i, .rd_data_o, .alt_clk_tick_i, .async_clk_tick_i,
    .stop_mode_i, .hw_trigger_i, .cmp_i, .conv_on_o, .sample_o,
    .low_power_o, .async_clk_run_o, .channel_o, .trial_o, .complete_o);
  always #5 clk_sys_i = ~clk_sys_i;
  // Alternate ticks every 3 cycles, asynchronous ticks every 5.
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    alt_clk_tick_i <= (cyc % 3 == 0);
    async_clk_tick_i <= (cyc % 5 == 0);
    cmp_i <= (trial_o <= vin);
  end
  task report_and_stop;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task cmp8(input [7:0] got, input [7:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input [1:0] a, input [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task chk_rd(input [1:0] a, input [7:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    cmp8(rd_data_o, exp);
  endtask
  // Counts sampling cycles of one conversion; 480 cycles keep tick phase.
  task samp(input [7:0] cfg, output int n);
    wr(2'h3, cfg);
    wr(2'h0, 8'h00);
    n = 0;
    repeat (477) begin
      @(negedge clk_sys_i);
      if (sample_o === 1'b1) n = n + 1;
    end
  endtask
  task conv;
    wr(2'h0, 8'h00);
    repeat (200) @(posedge clk_sys_i);
    cmp8({7'h00, complete_o}, 8'h01);
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch = n_mismatch + 1;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    chk_rd(2'h0, 8'h1F);
    chk_rd(2'h3, 8'h00);
    chk_rd(2'h1, 8'h00);
    chk_rd(2'h2, 8'h00);
    wr(2'h3, 8'hA6);
    chk_rd(2'h3, 8'hA6);
    wr(2'h0, 8'h9F);
    chk_rd(2'h0, 8'h1F);
    for (int i = 0; i < 4; i++) begin
      samp({1'b0, i[1:0], 5'b10000}, sh);
      samp({1'b0, i[1:0], 5'b10010}, ln);
      cmp8(8'(ln - sh), 8'd20 << i);
    end
    samp(8'h00, sh);
    samp(8'h02, ln);
    cmp8(8'(ln - sh), 8'd60);
    samp(8'h01, sh);
    samp(8'h03, ln);
    cmp8(8'(ln - sh), 8'd100);
    wr(2'h3, 8'h10);
    wr(2'h0, 8'h00);
    stop_mode_i <= 1'b1;
    repeat (50) @(posedge clk_sys_i);
    stop_mode_i <= 1'b0;
    cmp8({7'h00, complete_o}, 8'h00);
    wr(2'h3, 8'h11);
    wr(2'h0, 8'h00);
    stop_mode_i <= 1'b1;
    repeat (200) @(posedge clk_sys_i);
    stop_mode_i <= 1'b0;
    cmp8({7'h00, complete_o}, 8'h01);
    wr(2'h3, 8'h70);
    conv;
    chk_rd(2'h1, 8'h00);
    chk_rd(2'h2, 8'h55);
    vin <= 11'h7FF;
    conv;
    chk_rd(2'h2, 8'hFF);
    wr(2'h3, 8'h74);
    vin <= 11'h2A5;
    conv;
    chk_rd(2'h1, 8'h01);
    vin <= 11'h100;
    conv;
    chk_rd(2'h2, 8'h53);
    conv;
    chk_rd(2'h1, 8'h00);
    chk_rd(2'h2, 8'h80);
    wr(2'h3, 8'h70);
    vin <= 11'h2A5;
    conv;
    chk_rd(2'h1, 8'h00);
    vin <= 11'h7FF;
    conv;
    chk_rd(2'h2, 8'hFF);
    wr(2'h3, 8'h7C);
    vin <= 11'h2A5;
    wr(2'h0, 8'h00);
    repeat (200) @(posedge clk_sys_i);
    cmp8({7'h00, complete_o}, 8'h00);
    hw_trigger_i <= 1'b1;
    @(posedge clk_sys_i);
    hw_trigger_i <= 1'b0;
    repeat (200) @(posedge clk_sys_i);
    cmp8({7'h00, complete_o}, 8'h01);
    chk_rd(2'h2, 8'h53);
    wr(2'h0, 8'h1F);
    repeat (200) @(posedge clk_sys_i);
    cmp8({7'h00, complete_o}, 8'h00);
    report_and_stop;
  end
endmodule // arcc_top_tb
